// ### logic/port8_pkg.sv
// shared constants, register map and pin ownership decode for the 8-bit port
// assumes a classic Wishbone master with 32-bit data and word-aligned registers
package port8_pkg;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int PORT_W = 8;
	localparam int WB_ADDR_W = 18;
	localparam int WB_DATA_W = 32;
	localparam int WB_SEL_W = 4;
	localparam int WB_PAD_W = WB_DATA_W - PORT_W;
	localparam int SEG_SEL_W = 4;

	// ************************************************************
	// register map: offsets are word indices, the byte address is four times that
	// ************************************************************
	localparam logic [15:0] OUT_DATA_INDEX = 16'hffdb;
	localparam logic [15:0] DIR_INDEX = 16'hffeb;
	localparam int WORD_LSB = 2;

	// ************************************************************
	// reset and fixed read values
	// ************************************************************
	localparam logic [7:0] OUT_DATA_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] DIR_READBACK = 8'hff;
	localparam logic [7:0] PIN_IDLE = 8'h00;
	localparam logic [31:0] READ_NONE = 32'h0000_0000;

	// ************************************************************
	// pin ownership: pin n is general-purpose while the select field is at or
	// below its limit, otherwise the segment driver owns it (pin 7 in the top nibble)
	// ************************************************************
	localparam logic [31:0] GPIO_SEL_LIMIT = 32'h0111_1111;

	function automatic logic [7:0] gpio_mask(input logic [3:0] sel);
		logic [7:0] m;
		m = PIN_IDLE;
		for (int n = 0; n < PORT_W; n++) begin
			m[n] = (sel <= GPIO_SEL_LIMIT[n*SEG_SEL_W +: SEG_SEL_W]);
		end
		return m;
	endfunction

	function automatic logic reg_hit(input logic [17:0] adr, input logic [15:0] index);
		return adr[WB_ADDR_W-1:WORD_LSB] == index;
	endfunction

endpackage

// ### logic/port8_pin_sampler.sv
// registers the external pin levels once per clock
// assumes the pins are already synchronous to clk_i
module port8_pin_sampler
	import port8_pkg::*;
#(
	parameter int WIDTH = PORT_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o
);

	typedef struct packed {
		logic [WIDTH-1:0] level;
	} sample_type;

	sample_type state;
	sample_type next_state;

	always_comb begin
		next_state = state;
		next_state.level = pin_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state.level <= WIDTH'(PIN_IDLE);
		end else begin
			state <= next_state;
		end
	end

	assign level_o = state.level;

endmodule

// ### logic/port8_pin_driver.sv
// registered pin drive: general-purpose data or segment output, with enables
// assumes the segment driver output is synchronous to clk_i
module port8_pin_driver
	import port8_pkg::*;
#(
	parameter int WIDTH = PORT_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] gpio_i,
	input wire logic [WIDTH-1:0] dir_i,
	input wire logic [WIDTH-1:0] out_data_i,
	input wire logic [WIDTH-1:0] seg_i,
	output logic [WIDTH-1:0] pin_o,
	output logic [WIDTH-1:0] pin_oe_o
);

	typedef struct packed {
		logic [WIDTH-1:0] level;
		logic [WIDTH-1:0] enable;
	} drive_type;

	drive_type state;
	drive_type next_state;

	always_comb begin
		next_state = state;
		// general-purpose pins follow the registers, the rest follow the segment driver
		next_state.level = (gpio_i & out_data_i) | (~gpio_i & seg_i);
		next_state.enable = (gpio_i & dir_i) | ~gpio_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// pins float during reset
			state.level <= WIDTH'(PIN_IDLE);
			state.enable <= WIDTH'(PIN_IDLE);
		end else begin
			state <= next_state;
		end
	end

	assign pin_o = state.level;
	assign pin_oe_o = state.enable;

endmodule

// ### logic/port8_gpio_with_segment_share.sv
// 8-bit general-purpose port with a Wishbone register slave and segment sharing
// assumes a classic Wishbone master, pins synchronous to clk_i, and an external
// segment driver and segment-select field
module port8_gpio_with_segment_share
	import port8_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_ADDR_W-1:0] wb_adr_i,
	input wire logic [WB_SEL_W-1:0] wb_sel_i,
	input wire logic [WB_DATA_W-1:0] wb_dat_i,
	output logic [WB_DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [SEG_SEL_W-1:0] segment_select_field_i,
	input wire logic [PORT_W-1:0] lcd_segment_output_i,
	input wire logic [PORT_W-1:0] port_pins_7_to_0_i,
	output logic [PORT_W-1:0] port_pins_7_to_0_o,
	output logic [PORT_W-1:0] port_pins_7_to_0_oe_o
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic ack;
		logic [WB_DATA_W-1:0] rdata;
		logic [PORT_W-1:0] port_output_data;
		logic [PORT_W-1:0] pin_direction_control;
	} regs_type;

	regs_type state;
	regs_type next_state;

	logic req;
	logic take;
	logic commit;
	logic hit_data;
	logic hit_dir;
	logic [PORT_W-1:0] sampled;
	logic [PORT_W-1:0] gpio;
	logic [PORT_W-1:0] read_value;

	// ************************************************************
	// pin sampling and drive
	// ************************************************************
	port8_pin_sampler #(
		.WIDTH(PORT_W)
	) sampler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(port_pins_7_to_0_i),
		.level_o(sampled)
	);

	port8_pin_driver #(
		.WIDTH(PORT_W)
	) driver (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.gpio_i(gpio),
		.dir_i(state.pin_direction_control),
		.out_data_i(state.port_output_data),
		.seg_i(lcd_segment_output_i),
		.pin_o(port_pins_7_to_0_o),
		.pin_oe_o(port_pins_7_to_0_oe_o)
	);

	// ************************************************************
	// decode
	// ************************************************************
	assign req = wb_cyc_i & wb_stb_i;
	// a request is taken on the first cycle, answered and committed on the next
	assign take = req & ~state.ack;
	assign commit = req & state.ack & wb_we_i & wb_sel_i[0];
	assign hit_data = reg_hit(wb_adr_i, OUT_DATA_INDEX);
	assign hit_dir = reg_hit(wb_adr_i, DIR_INDEX);
	assign gpio = gpio_mask(segment_select_field_i);

	// output bits read back from the register, input bits from the pin
	assign read_value = (state.pin_direction_control & state.port_output_data)
		| (~state.pin_direction_control & sampled);

	// ************************************************************
	// register file
	// ************************************************************
	always_comb begin
		next_state = state;
		next_state.ack = take;
		if (take) begin
			if (hit_data) begin
				next_state.rdata = {WB_PAD_W'(0), read_value};
			end else if (hit_dir) begin
				next_state.rdata = {WB_PAD_W'(0), DIR_READBACK};
			end else begin
				next_state.rdata = READ_NONE;
			end
		end
		if (commit) begin
			if (hit_data) begin
				next_state.port_output_data = wb_dat_i[PORT_W-1:0];
			end else if (hit_dir) begin
				next_state.pin_direction_control = wb_dat_i[PORT_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state.ack <= 1'h0;
			state.rdata <= READ_NONE;
			state.port_output_data <= OUT_DATA_RESET;
			state.pin_direction_control <= DIR_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign wb_ack_o = state.ack;
	assign wb_dat_o = state.rdata;

	// ************************************************************
	// checks
	// ************************************************************
	ack_one_cycle_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		take |=> wb_ack_o ##1 !wb_ack_o
	) else $error("ack not a single cycle after request");

	data_reset_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> state.port_output_data == OUT_DATA_RESET
	) else $error("output data not cleared by reset");

	dir_reset_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> state.pin_direction_control == DIR_RESET
			&& (port_pins_7_to_0_oe_o & gpio) == PIN_IDLE
	) else $error("direction not cleared by reset");

	dir_reads_ones_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(take && !wb_we_i && hit_dir) |=> wb_ack_o && wb_dat_o == {WB_PAD_W'(0), DIR_READBACK}
	) else $error("direction register did not read as all ones");

	read_output_bits_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(take && !wb_we_i && hit_data) |=>
			(wb_dat_o[PORT_W-1:0] & $past(state.pin_direction_control))
			== ($past(state.port_output_data) & $past(state.pin_direction_control))
	) else $error("output bit read did not return stored data");

	read_input_bits_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(take && !wb_we_i && hit_data) |=>
			(wb_dat_o[PORT_W-1:0] & ~$past(state.pin_direction_control))
			== ($past(sampled) & ~$past(state.pin_direction_control))
	) else $error("input bit read did not return pin level");

	dir_write_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(commit && hit_dir) |=> state.pin_direction_control == $past(wb_dat_i[PORT_W-1:0])
			##1 (port_pins_7_to_0_oe_o & $past(gpio))
			== ($past(state.pin_direction_control) & $past(gpio))
	) else $error("direction write did not reach the pins");

	gpio_drive_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		##1 1'h1 |-> (port_pins_7_to_0_o & $past(gpio & state.pin_direction_control))
			== ($past(state.port_output_data) & $past(gpio & state.pin_direction_control))
	) else $error("output pin not driven with its data bit");

	segment_owned_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		##1 1'h1 |-> (port_pins_7_to_0_o & ~$past(gpio)) == ($past(lcd_segment_output_i) & ~$past(gpio))
			&& (port_pins_7_to_0_oe_o & ~$past(gpio)) == ~$past(gpio)
	) else $error("segment-owned pin not following the segment driver");

	no_stray_write_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!commit |=> $stable(state.port_output_data) && $stable(state.pin_direction_control)
	) else $error("register changed without a committed write");

	ack_needs_req_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |->
			$past(req)
	) else $error("ack given without a request");

	ack_pulse_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=>
			!wb_ack_o
	) else $error("ack held for more than one cycle");

	no_idle_ack_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!req |=>
			!wb_ack_o
	) else $error("ack given while the bus was idle");

	pad_zero_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		1'h1 |->
			wb_dat_o[WB_DATA_W-1:PORT_W] == '0
	) else $error("upper read data bits not zero");

	unmapped_read_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(take && !hit_data && !hit_dir) |=>
			wb_dat_o == READ_NONE
	) else $error("unmapped address did not read as zero");

	rdata_hold_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!take |=>
			$stable(wb_dat_o)
	) else $error("read data changed without a new access");

	masked_write_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && wb_ack_o && wb_we_i && !wb_sel_i[0]) |=>
			$stable(state.port_output_data) && $stable(state.pin_direction_control)
	) else $error("write without low byte enable changed a register");

	data_write_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(commit && hit_data) |=>
			state.port_output_data == $past(wb_dat_i[PORT_W-1:0])
	) else $error("output data write not stored");

	read_keeps_regs_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && wb_ack_o && !wb_we_i) |=>
			$stable(state.port_output_data) && $stable(state.pin_direction_control)
	) else $error("read access changed a register");

	dir_write_isolated_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(commit && hit_dir) |=>
			$stable(state.port_output_data)
	) else $error("direction write changed output data");

	data_write_isolated_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(commit && hit_data) |=>
			$stable(state.pin_direction_control)
	) else $error("output data write changed direction");

	input_released_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		##1 1'h1 |->
			(port_pins_7_to_0_oe_o & $past(gpio & ~state.pin_direction_control)) == PIN_IDLE
	) else $error("input pin driven by the port");

	output_enabled_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		##1 1'h1 |->
			(port_pins_7_to_0_oe_o & $past(gpio & state.pin_direction_control))
			== $past(gpio & state.pin_direction_control)
	) else $error("output pin not enabled");

	pin_sample_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		##1 1'h1 |->
			sampled == $past(port_pins_7_to_0_i)
	) else $error("pin level not sampled in one cycle");

	dir_read_harmless_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(take && !wb_we_i && hit_dir) |=>
			$stable(state.pin_direction_control)
	) else $error("direction read changed the direction register");

	sel_zero_port_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(segment_select_field_i == '0) |->
			gpio == '1
	) else $error("select zero did not give every pin to the port");

	oe_reset_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |->
			port_pins_7_to_0_oe_o == PIN_IDLE
	) else $error("pins driven after reset");

	pin_reset_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |->
			port_pins_7_to_0_o == PIN_IDLE
	) else $error("pin levels not cleared by reset");

	sample_reset_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |->
			sampled == PIN_IDLE
	) else $error("sampled levels not cleared by reset");

	rdata_reset_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |->
			wb_dat_o == READ_NONE && !wb_ack_o
	) else $error("bus outputs not cleared by reset");

endmodule

// ### verification/port8_board_model.sv
// board circuitry on the eight port pins
// assumes one clock; pins not driven by either side wander every cycle
module port8_board_model (
	input wire logic clk_i,
	input wire logic [7:0] pin_o_i,
	input wire logic [7:0] pin_oe_i,
	input wire logic [7:0] drive_i,
	input wire logic [7:0] drive_en_i,
	output logic [7:0] pin_i_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] churn = 8'h55;
	// an undriven line holds no value
	always @(posedge clk_i) begin
		churn <= ~churn;
	end
	assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & drive_en_i & drive_i)
		| (~pin_oe_i & ~drive_en_i & churn);
endmodule

// ### verification/port8_gpio_with_segment_share_tb.sv
// register and pin tests for the 8-bit port
// assumes the board model drives input pins with a pattern that the tests set
module port8_gpio_with_segment_share_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import port8_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [17:0] adr = 18'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, wb_dat_o, rd;
	logic wb_ack_o;
	logic [3:0] segsel = 4'h0;
	logic [7:0] lcd_segment_output = 8'h96, ext = 8'ha5, pin_in, pin_o, pin_oe;
	int n_fail = 0, n_tests = 0;
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	port8_gpio_with_segment_share i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .segment_select_field_i(segsel),
		.lcd_segment_output_i(lcd_segment_output), .port_pins_7_to_0_i(pin_in),
		.port_pins_7_to_0_o(pin_o), .port_pins_7_to_0_oe_o(pin_oe));
	port8_board_model i_board (.clk_i(clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
		.drive_i(ext), .drive_en_i(8'hff), .pin_i_o(pin_in));
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic test_done;
		if (n_fail == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d,
		input logic s0);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		sel <= {3'b000, s0};
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'h1);
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		idle(2);
		check({24'h0, pin_oe}, 32'h0);
		wb(1'b0, OUT_DATA_INDEX, 8'h00, 1'b1);
		check(rd, 32'ha5);
		wb(1'b0, DIR_INDEX, 8'h00, 1'b1);
		check(rd, 32'hff);
		wb(1'b1, OUT_DATA_INDEX, 8'h3c, 1'b1);
		wb(1'b1, DIR_INDEX, 8'h0f, 1'b1);
		idle(3);
		check({24'h0, pin_oe}, 32'h0f);
		check({24'h0, pin_o & 8'h0f}, 32'h0c);
		wb(1'b0, OUT_DATA_INDEX, 8'h00, 1'b1);
		check(rd, 32'hac);
		wb(1'b0, DIR_INDEX, 8'h00, 1'b1);
		check(rd, 32'hff);
		wb(1'b1, OUT_DATA_INDEX, 8'hff, 1'b0);
		wb(1'b0, OUT_DATA_INDEX, 8'h00, 1'b1);
		check(rd, 32'hac);
		wb(1'b0, 16'h0001, 8'h00, 1'b1);
		check(rd, READ_NONE);
		segsel <= 4'h1;
		idle(3);
		check({24'h0, pin_oe}, 32'h8f);
		check({24'h0, pin_o & 8'h8f}, 32'h8c);
		segsel <= 4'h2;
		idle(3);
		check({24'h0, pin_oe}, 32'hff);
		check({24'h0, pin_o}, 32'h96);
		wb(1'b0, OUT_DATA_INDEX, 8'h00, 1'b1);
		check(rd, 32'h9c);
		segsel <= 4'h0;
		ext <= 8'h5a;
		idle(3);
		wb(1'b0, OUT_DATA_INDEX, 8'h00, 1'b1);
		check(rd, 32'h5c);
		segsel <= 4'h0;
		rst_i <= 1'b1;
		idle(2);
		rst_i <= 1'b0;
		idle(3);
		check({24'h0, pin_oe}, 32'h0);
		wb(1'b1, DIR_INDEX, 8'hff, 1'b1);
		wb(1'b0, OUT_DATA_INDEX, 8'h00, 1'b1);
		check(rd, 32'h00);
		test_done;
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		n_fail++;
		test_done;
	end
endmodule
